//--- rtl/sfp_pkg.sv
// Shared constants for the serial flash pin interface
package sfp_pkg;
    // Opcodes
    localparam logic [7:0] CMD_STATUS_READ  = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_SECTOR_A     = 8'h20;
    localparam logic [7:0] CMD_SECTOR_B     = 8'hd8;
    localparam logic [7:0] CMD_ARRAY_A      = 8'hc7;
    localparam logic [7:0] CMD_ARRAY_B      = 8'h60;
    localparam logic [7:0] CMD_DEEP_SLEEP   = 8'hb9;
    localparam logic [7:0] CMD_WAKE_SIG     = 8'hab;
    localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] CMD_WRITE_LOCK   = 8'h04;
    // Status register layout
    localparam int         ST_BUSY_BIT   = 0;
    localparam int         ST_UNLOCK_BIT = 1;
    localparam int         ST_BP_LSB     = 2;
    localparam int         ST_BP_MSB     = 4;
    localparam int         ST_SRWD_BIT   = 7;
    localparam logic [7:0] ST_WRITE_MASK = 8'h9c;
    localparam logic [7:0] ST_RESET      = 8'h00;
    // Frame byte counts needed before a command may run
    localparam logic [2:0] LEN_OPCODE    = 3'h1;
    localparam logic [2:0] LEN_SR_WRITE  = 3'h2;
    localparam logic [2:0] LEN_ADDR      = 3'h4;
    localparam logic [2:0] LEN_PROGRAM   = 3'h5;
    localparam int         SECTOR_COUNT  = 64;
    // Operation kinds reported to the array side
    localparam logic [2:0] OP_NONE     = 3'h0;
    localparam logic [2:0] OP_SR_WRITE = 3'h1;
    localparam logic [2:0] OP_PROGRAM  = 3'h2;
    localparam logic [2:0] OP_SECTOR   = 3'h3;
    localparam logic [2:0] OP_ARRAY    = 3'h4;
    // Timing, in printed units, and derived cycle counts
    localparam longint CLK_MHZ          = 100;
    localparam longint PROG_TIME_US     = 1500;
    localparam longint ACC_PROG_TIME_US = 1200;
    localparam longint SR_WRITE_TIME_US = 1000;
    localparam longint SECTOR_TIME_MS   = 500;
    localparam longint ARRAY_TIME_S     = 128;
    localparam longint PROG_CYCLES      = PROG_TIME_US * CLK_MHZ;
    localparam longint ACC_PROG_CYCLES  = ACC_PROG_TIME_US * CLK_MHZ;
    localparam longint SR_WRITE_CYCLES  = SR_WRITE_TIME_US * CLK_MHZ;
    localparam longint SECTOR_CYCLES    = SECTOR_TIME_MS * 1000 * CLK_MHZ;
    localparam longint ARRAY_CYCLES     = ARRAY_TIME_S * 1000000 * CLK_MHZ;
    localparam int     TIMER_W          = 36;
    // Arbitrary signature value, not tied to any real part
    localparam logic [7:0] SIGNATURE_DEFAULT = 8'h5a;
endpackage : sfp_pkg

//--- rtl/sfp_serial_flash_pin_interface.sv
// Serial flash pin interface: link shifter on the serial clock, command core on clk
//
// What this block does
// - Serial input sampled on serial clock rising edge
// - Serial output changes after serial clock falling edge
// - Parallel bus captured rising, driven after falling
// - Chip select low selects, active power
// - Chip select high deselects, output tri-stated
// - No command acted on before select falling edge; select held low through reset counts as one
// - Standby once deselected and nothing running
// - Pause low freezes exchange, tri-states output
// - Protect pin low blocks writes to protected region
// - Elevated voltage on pin selects accelerated programming
// - Opcode 05h reads status register
// - Opcode 01h writes status register
// - Opcode 02h is page program
// - Opcodes 20h and D8h erase sector
// - Opcodes C7h and 60h erase whole array
// - Opcode B9h enters deep sleep
// - Opcode ABh wakes, returns one-byte signature
// - Write unlock latch set by command, cleared on completion
// - Modifying commands need clock count multiple of eight in serial mode
// - Busy status bit set while operation runs
`timescale 1ns/1ps

module sfp_serial_flash_pin_interface #(
    parameter longint     PROG_CYCLES     = sfp_pkg::PROG_CYCLES,
    parameter longint     ACC_PROG_CYCLES = sfp_pkg::ACC_PROG_CYCLES,
    parameter longint     SR_WRITE_CYCLES = sfp_pkg::SR_WRITE_CYCLES,
    parameter longint     SECTOR_CYCLES   = sfp_pkg::SECTOR_CYCLES,
    parameter longint     ARRAY_CYCLES    = sfp_pkg::ARRAY_CYCLES,
    parameter logic [7:0] SIGNATURE       = sfp_pkg::SIGNATURE_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        spiClk,
    input  wire logic        csN,
    input  wire logic        si,
    input  wire logic        holdN,
    input  wire logic        parallelMode,
    input  wire logic [7:0]  parallelDataBusIn,
    input  wire logic        protectAccelPin,
    input  wire logic        accelHighVoltage,
    output logic             soOut,
    output logic             soOe,
    output logic [7:0]       parallelDataBusOut,
    output logic             parallelDataBusOe,
    output logic             standby,
    output logic             deepSleep,
    output logic             writeBusyFlag,
    output logic             opStart,
    output logic [2:0]       opKind,
    output logic [23:0]      opAddr,
    output logic             opAccel
);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_BUSY  = 3'b010,
        ST_SLEEP = 3'b100
    } sfp_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: everything clocked by the master's serial clock
    ////////////////////////////////////////////////////////////////////////////
    logic        frameLive;
    logic [2:0]  bitPos;
    logic [2:0]  byteCnt;
    logic [7:0]  shiftIn;
    logic [7:0]  opcode;
    logic [23:0] addrIn;
    logic [7:0]  dataIn;
    logic [7:0]  statusMeta, statusLink;
    logic [1:0]  modeMeta, modeLink;
    logic [7:0]  rxByte;
    logic [7:0]  txByte;
    logic        txEn;
    logic        soBit;
    logic        txActive;
    logic        armed;
    sfp_state_t  state;
    logic [7:0]  status;

    // First edge of a frame after select falls; cleared the moment select rises
    always_ff @(posedge spiClk or posedge csN) begin
        if (csN) begin
            frameLive <= 1'b0;
        end else if (holdN) begin
            frameLive <= 1'b1;
        end
    end

    // Byte assembled this edge, MSB first or a whole parallel byte
    always_comb begin
        if (parallelMode) begin
            rxByte = parallelDataBusIn;
        end else begin
            rxByte = {shiftIn[6:0], si};
        end
    end

    // Shift and count; nothing moves while paused so the exchange resumes intact
    always_ff @(posedge spiClk or negedge rst_n) begin
        if (!rst_n) begin
            bitPos  <= 3'h0;
            byteCnt <= 3'h0;
            shiftIn <= 8'h00;
            opcode  <= 8'h00;
            addrIn  <= 24'h000000;
            dataIn  <= 8'h00;
        end else if (!csN && holdN) begin
            if (!frameLive) begin
                bitPos  <= parallelMode ? 3'h0 : 3'h1;
                byteCnt <= parallelMode ? 3'h1 : 3'h0;
                shiftIn <= rxByte;
                if (parallelMode) begin
                    opcode <= rxByte;
                end
            end else if (parallelMode || bitPos == 3'h7) begin
                bitPos  <= 3'h0;
                shiftIn <= rxByte;
                if (byteCnt != 3'h7) begin
                    byteCnt <= byteCnt + 3'h1;
                end
                case (byteCnt)
                    3'h0: opcode <= rxByte;
                    3'h1, 3'h2, 3'h3: addrIn <= {addrIn[15:0], rxByte};
                    default: ;
                endcase
                if (byteCnt == 3'h1) begin
                    dataIn <= rxByte;
                end
            end else begin
                bitPos  <= bitPos + 3'h1;
                shiftIn <= rxByte;
            end
        end
    end

    // Core state into the link domain; the status byte only changes at deselect or when an
    // operation ends, so a rare mixed sample just reads as the old value
    always_ff @(posedge spiClk or negedge rst_n) begin
        if (!rst_n) begin
            statusMeta <= sfp_pkg::ST_RESET;
            statusLink <= sfp_pkg::ST_RESET;
            modeMeta   <= 2'b00;
            modeLink   <= 2'b00;
        end else begin
            statusMeta <= {status[7:1], writeBusyFlag};
            statusLink <= statusMeta;
            modeMeta   <= {armed, state == ST_SLEEP};
            modeLink   <= modeMeta;
        end
    end

    // Answer byte for the running command
    always_comb begin
        txByte = 8'h00;
        txEn   = 1'b0;
        if (modeLink[1] && frameLive) begin
            if (opcode == sfp_pkg::CMD_STATUS_READ && !modeLink[0]
                    && byteCnt >= sfp_pkg::LEN_OPCODE) begin
                txByte = statusLink;
                txEn   = 1'b1;
            end else if (opcode == sfp_pkg::CMD_WAKE_SIG
                    && byteCnt >= sfp_pkg::LEN_ADDR) begin
                txByte = SIGNATURE;
                txEn   = 1'b1;
            end
        end
    end

    // Output changes on the falling edge, MSB first
    always_ff @(negedge spiClk or negedge rst_n) begin
        if (!rst_n) begin
            soBit              <= 1'b0;
            parallelDataBusOut <= 8'h00;
            txActive           <= 1'b0;
        end else if (!csN && holdN) begin
            soBit              <= txByte[3'h7 - bitPos];
            parallelDataBusOut <= txByte;
            txActive           <= txEn;
        end
    end

    // Tri-state follows the pins at once, not the next clock
    assign soOut             = soBit;
    assign soOe              = !csN && holdN && txActive && !parallelMode;
    assign parallelDataBusOe = !csN && holdN && txActive && parallelMode;

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: clk
    ////////////////////////////////////////////////////////////////////////////
    logic [2:0]                 pinMeta, pinSync;
    logic                       csPrev;
    logic [sfp_pkg::TIMER_W-1:0] timer;
    logic                       frameEnd;
    logic                       countOk;
    logic                       wpLow;
    logic                       regionLocked;
    logic [2:0]                 bpVal;
    logic                       isSector;
    logic                       isArray;
    logic [5:0]                 lockFloor;

    // Two-stage synchronisers for select, protect and elevated-voltage pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta <= 3'b011;
            pinSync <= 3'b011;
            csPrev  <= 1'b1;
        end else begin
            pinMeta <= {accelHighVoltage, protectAccelPin, csN};
            pinSync <= pinMeta;
            csPrev  <= pinSync[0];
        end
    end

    // Link registers are quiet once select is high, so they are read then
    assign frameEnd = pinSync[0] && !csPrev;
    assign countOk  = (bitPos == 3'h0) && (byteCnt != 3'h0);
    assign wpLow    = !pinSync[1];
    assign bpVal    = status[sfp_pkg::ST_BP_MSB:sfp_pkg::ST_BP_LSB];
    assign isSector = opcode == sfp_pkg::CMD_SECTOR_A || opcode == sfp_pkg::CMD_SECTOR_B;
    assign isArray  = opcode == sfp_pkg::CMD_ARRAY_A || opcode == sfp_pkg::CMD_ARRAY_B;

    // Top sectors locked: 1, 2, 4 ... by block-protect code, 7 locks all
    always_comb begin
        lockFloor = 6'(sfp_pkg::SECTOR_COUNT - (1 << (bpVal - 3'h1)));
        if (bpVal == 3'h0) begin
            regionLocked = 1'b0;
        end else if (bpVal == 3'h7) begin
            regionLocked = 1'b1;
        end else begin
            regionLocked = addrIn[23:18] >= lockFloor;
        end
    end

    // Armed by a select falling edge after reset; select held low through reset also arms it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else if (!pinSync[0] && csPrev) begin
            armed <= 1'b1;
        end
    end

    // Command execution at deselect, plus the busy timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= ST_IDLE;
            status  <= sfp_pkg::ST_RESET;
            timer   <= '0;
            opStart <= 1'b0;
            opKind  <= sfp_pkg::OP_NONE;
            opAddr  <= 24'h000000;
            opAccel <= 1'b0;
        end else begin
            opStart <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (frameEnd && armed) begin
                        if (opcode == sfp_pkg::CMD_WRITE_UNLOCK && countOk) begin
                            status[sfp_pkg::ST_UNLOCK_BIT] <= 1'b1;
                        end else if (opcode == sfp_pkg::CMD_WRITE_LOCK && countOk) begin
                            status[sfp_pkg::ST_UNLOCK_BIT] <= 1'b0;
                        end else if (opcode == sfp_pkg::CMD_DEEP_SLEEP && countOk) begin
                            state <= ST_SLEEP;
                        end else if (countOk && status[sfp_pkg::ST_UNLOCK_BIT]) begin
                            if (opcode == sfp_pkg::CMD_STATUS_WRITE
                                    && byteCnt >= sfp_pkg::LEN_SR_WRITE
                                    && !(wpLow && status[sfp_pkg::ST_SRWD_BIT])) begin
                                status <= (status & ~sfp_pkg::ST_WRITE_MASK)
                                        | (dataIn & sfp_pkg::ST_WRITE_MASK);
                                timer  <= sfp_pkg::TIMER_W'(SR_WRITE_CYCLES);
                                opKind <= sfp_pkg::OP_SR_WRITE;
                                state  <= ST_BUSY;
                            end else if (opcode == sfp_pkg::CMD_PAGE_PROGRAM
                                    && byteCnt >= sfp_pkg::LEN_PROGRAM
                                    && !(wpLow && regionLocked)) begin
                                timer   <= pinSync[2]
                                         ? sfp_pkg::TIMER_W'(ACC_PROG_CYCLES)
                                         : sfp_pkg::TIMER_W'(PROG_CYCLES);
                                opAccel <= pinSync[2];
                                opKind  <= sfp_pkg::OP_PROGRAM;
                                state   <= ST_BUSY;
                            end else if (isSector && byteCnt == sfp_pkg::LEN_ADDR
                                    && !(wpLow && regionLocked)) begin
                                timer  <= sfp_pkg::TIMER_W'(SECTOR_CYCLES);
                                opKind <= sfp_pkg::OP_SECTOR;
                                state  <= ST_BUSY;
                            end else if (isArray && byteCnt == sfp_pkg::LEN_OPCODE
                                    && !(wpLow && bpVal != 3'h0)) begin
                                timer  <= sfp_pkg::TIMER_W'(ARRAY_CYCLES);
                                opKind <= sfp_pkg::OP_ARRAY;
                                state  <= ST_BUSY;
                            end
                            opAddr  <= addrIn;
                            opStart <= opcode != sfp_pkg::CMD_STATUS_READ;
                        end
                    end
                end
                ST_BUSY: begin
                    // Frames are ignored while busy; the link side still answers status and signature reads
                    if (timer <= sfp_pkg::TIMER_W'(1)) begin
                        timer                          <= '0;
                        status[sfp_pkg::ST_UNLOCK_BIT] <= 1'b0;
                        opAccel                        <= 1'b0;
                        state                          <= ST_IDLE;
                    end else begin
                        timer <= timer - sfp_pkg::TIMER_W'(1);
                    end
                end
                ST_SLEEP: begin
                    if (frameEnd && opcode == sfp_pkg::CMD_WAKE_SIG
                            && byteCnt >= sfp_pkg::LEN_OPCODE) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Status flags and power indications
    assign writeBusyFlag = state == ST_BUSY;
    assign standby       = pinSync[0] && state == ST_IDLE;
    assign deepSleep     = state == ST_SLEEP;

endmodule : sfp_serial_flash_pin_interface

//--- sim/sfp_pin_assertions.sv
// Port checker for the serial flash pin interface
`timescale 1ns/1ps

module sfp_pin_assertions (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       csN,
    input wire logic       holdN,
    input wire logic       soOe,
    input wire logic       parallelDataBusOe,
    input wire logic       standby,
    input wire logic       deepSleep,
    input wire logic       writeBusyFlag,
    input wire logic       opStart,
    input wire logic [2:0] opKind,
    input wire logic       opAccel
);
    // All checks live in the core clock domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    a_cs_tristate: assert property (csN |-> !soOe && !parallelDataBusOe)
        else $error("output driven while deselected");
    a_hold_quiet: assert property (!holdN |-> !soOe && !parallelDataBusOe)
        else $error("output driven while paused");
    a_cs_active: assert property ((!csN) [*4] |-> !standby)
        else $error("standby while selected");
    // Eight cycles leave room for the select crossing and the frame-end decode
    a_idle_standby: assert property (csN [*8] ##0 (!writeBusyFlag && !deepSleep) |-> standby)
        else $error("no standby when idle and deselected");
    a_busy_start: assert property ($rose(writeBusyFlag) |-> opStart)
        else $error("busy rose without an accepted frame");
    a_busy_locked: assert property ($past(writeBusyFlag) && writeBusyFlag |-> !opStart)
        else $error("new operation started while busy");
    a_accel_kind: assert property (opAccel |-> writeBusyFlag && opKind == sfp_pkg::OP_PROGRAM)
        else $error("accelerated flag outside a program");
    a_start_kind: assert property (opStart |-> opKind inside {[3'h1:3'h4]})
        else $error("operation started with bad kind");
    a_sleep_standby: assert property (deepSleep |-> !standby)
        else $error("standby reported in deep sleep");

    // Main scenarios reached
    c_sector: cover property (opStart && opKind == sfp_pkg::OP_SECTOR);
    c_sleep: cover property (deepSleep);
    c_pause: cover property (!holdN && !csN);
    c_accel: cover property (opAccel);
endmodule : sfp_pin_assertions

bind sfp_serial_flash_pin_interface sfp_pin_assertions u_chk (
    .clk(clk), .rst_n(rst_n), .csN(csN), .holdN(holdN), .soOe(soOe),
    .parallelDataBusOe(parallelDataBusOe), .standby(standby), .deepSleep(deepSleep),
    .writeBusyFlag(writeBusyFlag), .opStart(opStart), .opKind(opKind), .opAccel(opAccel)
);

//--- sim/sfp_spi_master.sv
// Bus master model driving the serial link in clock mode 0
`timescale 1ns/1ps

module sfp_spi_master (
    output logic      spiClk,
    output logic      csN,
    output logic      si,
    output logic      holdN,
    input  wire logic so,
    input  wire logic soOe
);
    logic oeHeld;

    // Clock parked low between frames, deselected, pause released
    initial begin
        spiClk = 1'b0;
        csN = 1'b1;
        si = 1'b0;
        holdN = 1'b1;
        oeHeld = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One frame, MSB first, 12 ns clock; a pause after bit holdAt toggles the
    // clock and data on purpose, since a held device must ignore both
    task automatic frame(input int nbits, input logic [39:0] d, input int holdAt,
                         output logic [7:0] rx);
        rx = 8'h00;
        csN = 1'b0;
        #6;
        for (int i = 0; i < nbits; i++) begin
            si = d[39 - i];
            #6 spiClk = 1'b1;
            rx = {rx[6:0], so};
            #6 spiClk = 1'b0;
            if (i == holdAt) begin
                #3 holdN = 1'b0;
                #1 oeHeld = soOe;
                repeat (2) begin
                    #6 spiClk = 1'b1;
                    si = ~si;
                    #6 spiClk = 1'b0;
                end
                #3 holdN = 1'b1;
                #3;
            end
        end
        #6 csN = 1'b1;
        si = ~si;
        #48;
    endtask : frame
endmodule : sfp_spi_master

//--- sim/sfp_serial_flash_pin_interface_tb.sv
// Self-checking bench for the serial flash pin interface
`timescale 1ns/1ps

module sfp_serial_flash_pin_interface_tb;
    localparam longint     CYC = 40;
    localparam logic [7:0] SIG = 8'h3c; // Arbitrary signature value
    typedef struct {logic [7:0] op; int nbits; logic [2:0] kind;} sfp_row_t;
    sfp_row_t rows [6] = '{'{8'h01, 16, 3'h1}, '{8'h02, 40, 3'h2}, '{8'h20, 32, 3'h3},
                           '{8'hd8, 32, 3'h3}, '{8'hc7, 8, 3'h4}, '{8'h60, 8, 3'h4}};
    logic        clk = 1'b0, rst_n = 1'b0, parallelMode = 1'b0;
    logic        protectAccelPin = 1'b1, accelHighVoltage = 1'b0;
    logic [7:0]  parallelDataBusIn = 8'h00, parallelDataBusOut, rx;
    logic        soOut, soOe, parallelDataBusOe, standby, deepSleep;
    logic        writeBusyFlag, opStart, opAccel, parSeen = 1'b0;
    logic [2:0]  opKind, kindSeen;
    logic [23:0] opAddr;
    wire         spiClk, csN, si, holdN, soWire;
    int          miscompares = 0, compares = 0;
    int          starts = 0, startBase = 0;

    sfp_serial_flash_pin_interface #(.PROG_CYCLES(CYC), .ACC_PROG_CYCLES(CYC),
        .SR_WRITE_CYCLES(CYC), .SECTOR_CYCLES(CYC), .ARRAY_CYCLES(CYC), .SIGNATURE(SIG))
        u_dut (.clk(clk), .rst_n(rst_n), .spiClk(spiClk), .csN(csN), .si(si), .holdN(holdN),
               .parallelMode(parallelMode), .parallelDataBusIn(parallelDataBusIn),
               .protectAccelPin(protectAccelPin), .accelHighVoltage(accelHighVoltage),
               .soOut(soOut), .soOe(soOe), .parallelDataBusOut(parallelDataBusOut),
               .parallelDataBusOe(parallelDataBusOe), .standby(standby), .deepSleep(deepSleep),
               .writeBusyFlag(writeBusyFlag), .opStart(opStart), .opKind(opKind),
               .opAddr(opAddr), .opAccel(opAccel));
    sfp_spi_master u_mst (.spiClk(spiClk), .csN(csN), .si(si), .holdN(holdN),
                          .so(soWire), .soOe(soOe));

    // Released output floats; a stale bit must not pass for data
    assign soWire = soOe ? soOut : 1'bz;
    always #5 clk = ~clk;
    // Start pulse is one cycle and may come before the frame task returns
    always @(posedge clk) begin
        if (opStart === 1'b1) begin
            starts <= starts + 1;
            kindSeen <= opKind;
        end
        if (parallelDataBusOe === 1'b1) parSeen <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim

    task automatic chkv(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkv

    task automatic chkb(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkb

    task automatic cmd(input int nbits, input logic [39:0] d, input int holdAt = -1);
        startBase = starts;
        u_mst.frame(nbits, d, holdAt, rx);
    endtask : cmd

    task automatic unlock;
        cmd(8, 40'h0600000000);
    endtask : unlock

    // Bounded waits; running out ends the run as a failure
    task automatic wait_start;
        for (int n = 0; n < 20; n++) begin
            if (starts != startBase) return;
            @(posedge clk);
        end
        miscompares++;
        end_sim();
    endtask : wait_start

    task automatic wait_idle;
        for (int n = 0; n < 200; n++) begin
            @(posedge clk);
            #1;
            if (writeBusyFlag === 1'b0) return;
        end
        miscompares++;
        end_sim();
    endtask : wait_idle

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chkb(soOe, 1'b0);
        chkb(standby, 1'b1);
        // Every modifying opcode, each behind its own unlock
        foreach (rows[i]) begin
            unlock();
            cmd(16, 40'h0500000000);
            chkv(24'(rx), 24'h02);
            cmd(rows[i].nbits, {rows[i].op, 32'h00a5c300});
            wait_start();
            chkv(24'(kindSeen), 24'(rows[i].kind));
            chkb(writeBusyFlag, 1'b1);
            chkb(standby, 1'b0);
            if (rows[i].kind == 3'h3) chkv(opAddr, 24'h00a5c3);
            wait_idle();
            cmd(16, 40'h0500000000);
            chkv(24'(rx), 24'h00);
        end
        // Accelerated program, status polled mid-operation
        @(posedge clk) accelHighVoltage <= 1'b1;
        unlock();
        cmd(40, 40'h0200000011);
        wait_start();
        chkb(opAccel, 1'b1);
        cmd(16, 40'h0500000000);
        chkv(24'(rx), 24'h03);
        wait_idle();
        @(posedge clk) accelHighVoltage <= 1'b0;
        // Frame one bit past a byte boundary
        unlock();
        cmd(33, 40'h20000000ff);
        repeat (3) @(posedge clk);
        chkv(24'(starts - startBase), 24'h0);
        // Lock everything, then erase with protection low and high
        unlock();
        cmd(16, 40'h011c000000);
        wait_start();
        wait_idle();
        @(posedge clk) protectAccelPin <= 1'b0;
        unlock();
        cmd(32, 40'hd8fc000000);
        repeat (3) @(posedge clk);
        chkb(writeBusyFlag, 1'b0);
        @(posedge clk) protectAccelPin <= 1'b1;
        unlock();
        cmd(32, 40'hd8fc000000);
        wait_start();
        chkb(writeBusyFlag, 1'b1);
        wait_idle();
        unlock();
        cmd(16, 40'h0100000000);
        wait_start();
        wait_idle();
        // Pause in mid-read with clock and data wiggling
        unlock();
        cmd(16, 40'h0500000000, 10);
        chkv(24'(rx), 24'h02);
        chkb(u_mst.oeHeld, 1'b0);
        // Parallel status read: opcode held on the byte bus, answer comes back on it
        unlock();
        @(posedge clk) begin
            parallelMode <= 1'b1;
            parallelDataBusIn <= 8'h05;
        end
        cmd(3, 40'h0000000000);
        chkv(24'(parallelDataBusOut), 24'h02);
        chkb(parSeen, 1'b1);
        @(posedge clk) parallelMode <= 1'b0;
        // Deep sleep refuses erase, wake returns the signature
        cmd(8, 40'hb900000000);
        repeat (3) @(posedge clk);
        chkb(deepSleep, 1'b1);
        unlock();
        cmd(8, 40'hc700000000);
        repeat (3) @(posedge clk);
        chkb(writeBusyFlag, 1'b0);
        cmd(40, 40'hab00000000);
        chkv(24'(rx), 24'(SIG));
        repeat (3) @(posedge clk);
        chkb(deepSleep, 1'b0);
        end_sim();
    end
endmodule : sfp_serial_flash_pin_interface_tb
